/* File: ebls_top.sv */
// Endian byte-lane steering between the core load/store port and a 32-bit bus.
// Assumes the bus answers a read in the cycle after the request and the core waits for it.
`timescale 1ns/1ps

module ebls_top
  import ebls_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_i,
  input  wire logic                 big_endian_strap_i,
  input  wire logic                 req_i,
  input  wire logic                 write_i,
  input  wire logic                 signed_i,
  input  wire ebls_pkg::ebls_size_t size_i,
  input  wire logic [31:0]          addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic [31:0]          bus_rdata_i,
  output logic                      big_endian_o,
  output logic                      bus_req_o,
  output logic                      bus_write_o,
  output ebls_pkg::ebls_size_t      bus_size_o,
  output logic [31:0]               bus_addr_o,
  output logic [31:0]               bus_wdata_o,
  output logic [3:0]                bus_be_o,
  output logic                      rvalid_o,
  output logic [31:0]               rdata_o
);
  import ebls_pkg::*;

  logic              mode_q;
  logic              init_q;
  logic              rd_pend_q;
  ebls_size_t        rd_size_q;
  logic [1:0]        rd_off_q;
  logic              rd_sgn_q;
  logic [31:0]       st_bus;
  logic [3:0]        st_be;
  logic [31:0]       ld_data;

  // Strap sampled on the first edge after reset; never changes in operation
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_q <= RESET_MODE;
      init_q <= 1'b1;
    end else if (init_q) begin
      mode_q <= big_endian_strap_i;
      init_q <= 1'b0;
    end
  end

  ebls_store_steer u_store (
    .big_i  (mode_q),
    .size_i (size_i),
    .off_i  (addr_i[1:0]),
    .data_i (wdata_i),
    .bus_o  (st_bus),
    .be_o   (st_be)
  );

  ebls_load_align u_load (
    .big_i    (mode_q),
    .size_i   (rd_size_q),
    .off_i    (rd_off_q),
    .signed_i (rd_sgn_q),
    .bus_i    (bus_rdata_i),
    .data_o   (ld_data)
  );

  // Request stage; requests during the strap capture cycle are dropped
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bus_req_o   <= 1'b0;
      bus_write_o <= 1'b0;
      bus_size_o  <= EBLS_SIZE_WORD;
      bus_addr_o  <= 32'h0;
      bus_wdata_o <= 32'h0;
      bus_be_o    <= 4'h0;
    end else begin
      bus_req_o   <= req_i & ~init_q;
      bus_write_o <= write_i;
      bus_size_o  <= size_i;
      bus_addr_o  <= addr_i;
      bus_wdata_o <= st_bus;
      bus_be_o    <= (req_i & ~init_q) ? st_be : 4'h0;
    end
  end

  // Read bookkeeping: data returns the cycle after the bus request
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rd_pend_q <= 1'b0;
      rd_size_q <= EBLS_SIZE_WORD;
      rd_off_q  <= 2'h0;
      rd_sgn_q  <= 1'b0;
    end else begin
      rd_pend_q <= bus_req_o & ~bus_write_o;
      rd_size_q <= bus_size_o;
      rd_off_q  <= bus_addr_o[1:0];
      rd_sgn_q  <= signed_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= 32'h0;
    end else begin
      rvalid_o <= rd_pend_q;
      rdata_o  <= rd_pend_q ? ld_data : rdata_o;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      big_endian_o <= 1'b0;
    end else begin
      big_endian_o <= mode_q;
    end
  end

  a_mode_fixed: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !init_q && !$past(init_q) |-> $stable(mode_q))
    else $error("endian mode changed during operation");

  a_addr_same: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q |=> bus_addr_o == $past(addr_i) && bus_size_o == $past(size_i))
    else $error("bus address or width altered");

  a_word_pass: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && size_i == EBLS_SIZE_WORD |=>
      bus_wdata_o == $past(wdata_i) && bus_be_o == 4'hF)
    else $error("word store not bit preserving");

  a_le_byte_lane: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && !mode_q && size_i == EBLS_SIZE_BYTE
      && addr_i[1:0] == 2'h0 |=> bus_be_o == 4'h1 && bus_wdata_o[7:0] == $past(wdata_i[7:0]))
    else $error("little-endian byte 0 on wrong lane");

  a_be_byte_lane: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && mode_q && size_i == EBLS_SIZE_BYTE
      && addr_i[1:0] == 2'h0 |=> bus_be_o == 4'h8 && bus_wdata_o[31:24] == $past(wdata_i[7:0]))
    else $error("big-endian byte 0 on wrong lane");

  a_be_load_one: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && mode_q && rd_size_q == EBLS_SIZE_BYTE && rd_off_q == 2'h1 && !rd_sgn_q
      |=> rvalid_o && rdata_o == {24'h0, $past(bus_rdata_i[23:16])})
    else $error("big-endian byte 1 load wrong");

  a_le_load_one: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && !mode_q && rd_size_q == EBLS_SIZE_BYTE && rd_off_q == 2'h1 && !rd_sgn_q
      |=> rvalid_o && rdata_o == {24'h0, $past(bus_rdata_i[15:8])})
    else $error("little-endian byte 1 load wrong");

  a_word_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && rd_size_q == EBLS_SIZE_WORD |=> rdata_o == $past(bus_rdata_i))
    else $error("word load not bit preserving");

  a_byte_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && rd_size_q == EBLS_SIZE_BYTE && !rd_sgn_q |=> rdata_o[31:8] == 24'h0)
    else $error("unsigned byte load not zero filled");

  a_half_order: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && !mode_q && size_i == EBLS_SIZE_HALF && addr_i[1:0] == 2'h2
      |=> bus_wdata_o[31:16] == $past(wdata_i[15:0]) && bus_be_o == 4'hC)
    else $error("halfword significance order wrong");

  a_be_half: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && mode_q && size_i == EBLS_SIZE_HALF && addr_i[1:0] == 2'h0
      |=> bus_wdata_o[31:16] == $past(wdata_i[15:0]) && bus_be_o == 4'hC)
    else $error("big-endian halfword lanes wrong");

  // Mode capture and request gating around the strap cycle, bus direction copy and byte access width
  a_mode_capture: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    init_q |=> mode_q == $past(big_endian_strap_i))
    else $error("strap not captured after reset");

  a_mode_shown: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !init_q |=> big_endian_o == $past(mode_q))
    else $error("mode output does not follow mode");

  a_no_req: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !req_i || init_q |=> !bus_req_o && bus_be_o == 4'h0)
    else $error("bus request without a taken core request");

  a_write_copy: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q |=> bus_req_o && bus_write_o == $past(write_i))
    else $error("bus direction altered");

  a_byte_width: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && size_i == EBLS_SIZE_BYTE
      |=> bus_size_o == EBLS_SIZE_BYTE && $onehot(bus_be_o))
    else $error("byte access not one lane wide");

  // One property per mode and offset, so a failure names the lane at once
  a_le_byte_one: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && !mode_q && size_i == EBLS_SIZE_BYTE
      && addr_i[1:0] == 2'h1 |=> bus_be_o == 4'h2 && bus_wdata_o[15:8] == $past(wdata_i[7:0]))
    else $error("little-endian byte 1 on wrong lane");

  a_le_byte_two: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && !mode_q && size_i == EBLS_SIZE_BYTE
      && addr_i[1:0] == 2'h2 |=> bus_be_o == 4'h4 && bus_wdata_o[23:16] == $past(wdata_i[7:0]))
    else $error("little-endian byte 2 on wrong lane");

  a_le_byte_three: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && !mode_q && size_i == EBLS_SIZE_BYTE
      && addr_i[1:0] == 2'h3 |=> bus_be_o == 4'h8 && bus_wdata_o[31:24] == $past(wdata_i[7:0]))
    else $error("little-endian byte 3 on wrong lane");

  a_be_byte_one: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && mode_q && size_i == EBLS_SIZE_BYTE
      && addr_i[1:0] == 2'h1 |=> bus_be_o == 4'h4 && bus_wdata_o[23:16] == $past(wdata_i[7:0]))
    else $error("big-endian byte 1 on wrong lane");

  a_be_byte_two: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && mode_q && size_i == EBLS_SIZE_BYTE
      && addr_i[1:0] == 2'h2 |=> bus_be_o == 4'h2 && bus_wdata_o[15:8] == $past(wdata_i[7:0]))
    else $error("big-endian byte 2 on wrong lane");

  a_be_byte_three: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && mode_q && size_i == EBLS_SIZE_BYTE
      && addr_i[1:0] == 2'h3 |=> bus_be_o == 4'h1 && bus_wdata_o[7:0] == $past(wdata_i[7:0]))
    else $error("big-endian byte 3 on wrong lane");

  a_le_half_low: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && !mode_q && size_i == EBLS_SIZE_HALF && addr_i[1:0] == 2'h0
      |=> bus_wdata_o[15:0] == $past(wdata_i[15:0]) && bus_be_o == 4'h3)
    else $error("little-endian low halfword lanes wrong");

  a_be_half_high: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    req_i && !init_q && write_i && mode_q && size_i == EBLS_SIZE_HALF && addr_i[1:0] == 2'h2
      |=> bus_wdata_o[15:0] == $past(wdata_i[15:0]) && bus_be_o == 4'h3)
    else $error("big-endian upper halfword lanes wrong");

  a_le_load_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && !mode_q && rd_size_q == EBLS_SIZE_BYTE && rd_off_q == 2'h0
      |=> rvalid_o && rdata_o[7:0] == $past(bus_rdata_i[7:0]))
    else $error("little-endian byte 0 load wrong");

  a_le_load_two: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && !mode_q && rd_size_q == EBLS_SIZE_BYTE && rd_off_q == 2'h2
      |=> rvalid_o && rdata_o[7:0] == $past(bus_rdata_i[23:16]))
    else $error("little-endian byte 2 load wrong");

  a_le_load_three: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && !mode_q && rd_size_q == EBLS_SIZE_BYTE && rd_off_q == 2'h3
      |=> rvalid_o && rdata_o[7:0] == $past(bus_rdata_i[31:24]))
    else $error("little-endian byte 3 load wrong");

  a_be_load_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && mode_q && rd_size_q == EBLS_SIZE_BYTE && rd_off_q == 2'h0
      |=> rvalid_o && rdata_o[7:0] == $past(bus_rdata_i[31:24]))
    else $error("big-endian byte 0 load wrong");

  a_be_load_two: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && mode_q && rd_size_q == EBLS_SIZE_BYTE && rd_off_q == 2'h2
      |=> rvalid_o && rdata_o[7:0] == $past(bus_rdata_i[15:8]))
    else $error("big-endian byte 2 load wrong");

  a_be_load_three: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && mode_q && rd_size_q == EBLS_SIZE_BYTE && rd_off_q == 2'h3
      |=> rvalid_o && rdata_o[7:0] == $past(bus_rdata_i[7:0]))
    else $error("big-endian byte 3 load wrong");

  a_le_half_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && !mode_q && rd_size_q == EBLS_SIZE_HALF && rd_off_q == 2'h2
      |=> rvalid_o && rdata_o[15:0] == $past(bus_rdata_i[31:16]))
    else $error("little-endian upper halfword load wrong");

  a_be_half_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && mode_q && rd_size_q == EBLS_SIZE_HALF && rd_off_q == 2'h2
      |=> rvalid_o && rdata_o[15:0] == $past(bus_rdata_i[15:0]))
    else $error("big-endian upper halfword load wrong");

  a_le_half_base: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && !mode_q && rd_size_q == EBLS_SIZE_HALF && rd_off_q == 2'h0
      |=> rvalid_o && rdata_o[15:0] == $past(bus_rdata_i[15:0]))
    else $error("little-endian low halfword load wrong");

  a_be_half_base: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && mode_q && rd_size_q == EBLS_SIZE_HALF && rd_off_q == 2'h0
      |=> rvalid_o && rdata_o[15:0] == $past(bus_rdata_i[31:16]))
    else $error("big-endian low halfword load wrong");

  // Extension of narrow loads into the upper register bits, and hold of the load result between loads
  a_byte_sign: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && rd_size_q == EBLS_SIZE_BYTE && rd_sgn_q
      |=> rdata_o[31:8] == {24{rdata_o[7]}})
    else $error("signed byte load not sign extended");

  a_half_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && rd_size_q == EBLS_SIZE_HALF && !rd_sgn_q
      |=> rdata_o[31:16] == 16'h0)
    else $error("unsigned halfword load not zero filled");

  a_half_sign: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_pend_q && rd_size_q == EBLS_SIZE_HALF && rd_sgn_q
      |=> rdata_o[31:16] == {16{rdata_o[15]}})
    else $error("signed halfword load not sign extended");

  a_load_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !rd_pend_q |=> !rvalid_o && $stable(rdata_o))
    else $error("load result changed without a load");
endmodule // ebls_top

/* File: ebls_pkg.sv */
// Package for the endian byte-lane steering block: widths, size codes, lane constants.
// Assumes a 32-bit bus with four 8-bit byte lanes.
package ebls_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned LANE_W     = 8;
  localparam int unsigned ADDR_W     = 32;
  localparam logic [1:0]  LAST_LANE  = 2'h3;
  localparam logic        RESET_MODE = 1'b0;

  // Transfer-width codes, identical in both modes
  typedef enum logic [1:0] {
    EBLS_SIZE_BYTE = 2'h0,
    EBLS_SIZE_HALF = 2'h1,
    EBLS_SIZE_WORD = 2'h3
  } ebls_size_t;

  // Lane that carries byte offset off; big-endian mirrors it
  function automatic logic [1:0] ebls_lane(input logic big, input logic [1:0] off);
    return big ? (LAST_LANE - off) : off;
  endfunction
endpackage

/* File: ebls_load_align.sv */
// Load alignment: picks the addressed lanes of bus read data and zero/sign extends.
// Assumes bus data and the offset are valid in the same cycle; purely combinational.
`timescale 1ns/1ps
module ebls_load_align
  import ebls_pkg::*;
(
  input  wire logic                 big_i,
  input  wire ebls_pkg::ebls_size_t size_i,
  input  wire logic [1:0]           off_i,
  input  wire logic                 signed_i,
  input  wire logic [31:0]          bus_i,
  output logic      [31:0]          data_o
);
  logic [7:0] b0;
  logic [7:0] b1;
  logic [1:0] l0;
  logic [1:0] l1;

  always_comb begin
    l0 = ebls_lane(big_i, off_i);
    l1 = ebls_lane(big_i, off_i | 2'h1);
    b0 = bus_i[l0*LANE_W +: LANE_W];
    b1 = bus_i[l1*LANE_W +: LANE_W];
    unique case (size_i)
      EBLS_SIZE_BYTE: data_o = {{24{signed_i & b0[7]}}, b0};
      EBLS_SIZE_HALF: begin
        // Halfword: lower address is the low byte only in little-endian
        if (big_i) begin
          data_o = {{16{signed_i & b0[7]}}, b0, b1};
        end else begin
          data_o = {{16{signed_i & b1[7]}}, b1, b0};
        end
      end
      default: data_o = bus_i;
    endcase
  end
endmodule // ebls_load_align

/* File: ebls_store_steer.sv */
// Store steering: places register bytes onto the lanes of their byte addresses.
// Assumes unused lanes are don't-care to memory and masked by the byte enables.
`timescale 1ns/1ps
module ebls_store_steer
  import ebls_pkg::*;
(
  input  wire logic                 big_i,
  input  wire ebls_pkg::ebls_size_t size_i,
  input  wire logic [1:0]           off_i,
  input  wire logic [31:0]          data_i,
  output logic      [31:0]          bus_o,
  output logic      [3:0]           be_o
);
  logic [1:0] l0;
  logic [1:0] l1;

  always_comb begin
    bus_o = 32'h0;
    be_o  = 4'h0;
    l0    = ebls_lane(big_i, off_i);
    l1    = ebls_lane(big_i, off_i | 2'h1);
    unique case (size_i)
      EBLS_SIZE_BYTE: begin
        bus_o[l0*LANE_W +: LANE_W] = data_i[7:0];
        be_o[l0] = 1'b1;
      end
      EBLS_SIZE_HALF: begin
        // Arithmetic significance follows bit number in both modes
        if (big_i) begin
          bus_o[l0*LANE_W +: LANE_W] = data_i[15:8];
          bus_o[l1*LANE_W +: LANE_W] = data_i[7:0];
        end else begin
          bus_o[l0*LANE_W +: LANE_W] = data_i[7:0];
          bus_o[l1*LANE_W +: LANE_W] = data_i[15:8];
        end
        be_o[l0] = 1'b1;
        be_o[l1] = 1'b1;
      end
      default: begin
        bus_o = data_i;
        be_o  = 4'hF;
      end
    endcase
  end
endmodule // ebls_store_steer

/* File: ebls_mem_model.sv */
// Behavioural system memory on the far side of the lane steering block.
// Assumes one request per cycle; read data is shown in the cycle after bus_req.
`timescale 1ns/1ps
module ebls_mem_model
  import ebls_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        bus_req_i,
  input  wire logic        bus_write_i,
  input  wire logic [31:0] bus_addr_i,
  input  wire logic [31:0] bus_wdata_i,
  input  wire logic [3:0]  bus_be_i,
  output logic      [31:0] bus_rdata_o
);
  logic [31:0] mem_q [16];
  logic [31:0] data_q;
  logic        pend_q = 1'b0;
  logic [31:0] junk_q = 32'h5A5AC3C3;

  // Lanes stored by bit number, never swapped
  always_ff @(posedge clk_sys_i) begin
    if (bus_req_i && bus_write_i) begin
      for (int i = 0; i < 4; i++) begin
        if (bus_be_i[i]) begin
          mem_q[bus_addr_i[5:2]][i*8 +: 8] <= bus_wdata_i[i*8 +: 8];
        end
      end
    end
    pend_q <= bus_req_i && !bus_write_i;
    data_q <= mem_q[bus_addr_i[5:2]];
    junk_q <= ~junk_q;
  end

  // Off-cycle data toggles so a late sample never matches by luck
  assign bus_rdata_o = pend_q ? data_q : junk_q;
endmodule // ebls_mem_model

/* File: ebls_top_test.sv */
// Self-checking bench for the lane steering block, both modes.
// Assumes the memory model answers reads in the cycle after bus_req.
`timescale 1ns/1ps
`define EBLS_CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module ebls_top_test;
  import ebls_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        strap     = 1'b0;
  logic        req       = 1'b0;
  logic        wr        = 1'b0;
  logic        sg        = 1'b0;
  ebls_size_t  sz        = EBLS_SIZE_WORD;
  logic [31:0] addr      = 32'h0;
  logic [31:0] wdata     = 32'h0;
  logic [31:0] bus_rdata, bus_addr, bus_wdata, rdata;
  logic        big_o, bus_req, bus_write, rvalid;
  ebls_size_t  bus_size;
  logic [3:0]  bus_be;
  int          bad_count = 0;
  int          checks    = 0;

  ebls_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .big_endian_strap_i(strap),
    .req_i(req), .write_i(wr), .signed_i(sg), .size_i(sz), .addr_i(addr),
    .wdata_i(wdata), .bus_rdata_i(bus_rdata), .big_endian_o(big_o), .bus_req_o(bus_req),
    .bus_write_o(bus_write), .bus_size_o(bus_size), .bus_addr_o(bus_addr),
    .bus_wdata_o(bus_wdata), .bus_be_o(bus_be), .rvalid_o(rvalid), .rdata_o(rdata));
  ebls_mem_model u_mem (.clk_sys_i(clk_sys_i), .bus_req_i(bus_req), .bus_write_i(bus_write),
    .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata), .bus_be_i(bus_be),
    .bus_rdata_o(bus_rdata));

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic big);
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    strap <= big;
    repeat (7) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    strap <= ~big;
    #1;
    `EBLS_CHK(big_o, big)
  endtask

  task automatic access(input logic w, input ebls_size_t s, input logic [31:0] a,
                        input logic [31:0] d, input logic sgn, output logic [31:0] rd);
    @(posedge clk_sys_i);
    req <= 1'b1;
    wr <= w;
    sz <= s;
    addr <= a;
    wdata <= d;
    sg <= sgn;
    @(posedge clk_sys_i);
    req <= 1'b0;
    #1;
    `EBLS_CHK(bus_req, 1'b1)
    `EBLS_CHK(bus_addr, a)
    `EBLS_CHK(bus_size, s)
    `EBLS_CHK(bus_write, w)
    rd = bus_wdata;
    if (!w) begin
      repeat (2) @(posedge clk_sys_i);
      #1;
      `EBLS_CHK(rvalid, 1'b1)
      rd = rdata;
    end
  endtask

  task automatic t_bytes(input logic big);
    logic [31:0] rd;
    logic [1:0]  ln;
    for (int i = 0; i < 4; i++) begin
      ln = big ? 2'(3 - i) : 2'(i);
      access(1'b1, EBLS_SIZE_BYTE, 32'h10 + i, 32'hA0 + i, 1'b0, rd);
      `EBLS_CHK(bus_be, 4'(1 << ln))
      `EBLS_CHK(rd[ln*8 +: 8], 8'(8'hA0 + i))
    end
    access(1'b0, EBLS_SIZE_WORD, 32'h10, 32'h0, 1'b0, rd);
    `EBLS_CHK(rd, (big ? 32'hA0A1A2A3 : 32'hA3A2A1A0))
    access(1'b0, EBLS_SIZE_BYTE, 32'h11, 32'h0, 1'b0, rd);
    `EBLS_CHK(rd, 32'h000000A1)
    access(1'b0, EBLS_SIZE_BYTE, 32'h12, 32'h0, 1'b1, rd);
    `EBLS_CHK(rd, 32'hFFFFFFA2)
    access(1'b0, EBLS_SIZE_BYTE, 32'h10, 32'h0, 1'b0, rd);
    `EBLS_CHK(rd, 32'h000000A0)
    access(1'b0, EBLS_SIZE_BYTE, 32'h13, 32'h0, 1'b0, rd);
    `EBLS_CHK(rd, 32'h000000A3)
    $display("bytes test done, big mode %0d", big);
  endtask

  task automatic t_half(input logic big);
    logic [31:0] rd;
    access(1'b1, EBLS_SIZE_WORD, 32'h20, 32'h12345678, 1'b0, rd);
    `EBLS_CHK(rd, 32'h12345678)
    `EBLS_CHK(bus_be, 4'hF)
    access(1'b1, EBLS_SIZE_HALF, 32'h22, 32'h0000BEEF, 1'b0, rd);
    `EBLS_CHK(bus_be, (big ? 4'h3 : 4'hC))
    `EBLS_CHK((big ? rd[15:0] : rd[31:16]), 16'hBEEF)
    access(1'b0, EBLS_SIZE_WORD, 32'h20, 32'h0, 1'b0, rd);
    `EBLS_CHK(rd, (big ? 32'h1234BEEF : 32'hBEEF5678))
    access(1'b0, EBLS_SIZE_HALF, 32'h22, 32'h0, 1'b0, rd);
    `EBLS_CHK(rd, 32'h0000BEEF)
    access(1'b0, EBLS_SIZE_HALF, 32'h22, 32'h0, 1'b1, rd);
    `EBLS_CHK(rd, 32'hFFFFBEEF)
    access(1'b1, EBLS_SIZE_HALF, 32'h20, 32'h0000CAFE, 1'b0, rd);
    `EBLS_CHK(bus_be, (big ? 4'hC : 4'h3))
    `EBLS_CHK((big ? rd[31:16] : rd[15:0]), 16'hCAFE)
    access(1'b0, EBLS_SIZE_WORD, 32'h20, 32'h0, 1'b0, rd);
    `EBLS_CHK(rd, (big ? 32'hCAFEBEEF : 32'hBEEFCAFE))
    access(1'b0, EBLS_SIZE_HALF, 32'h20, 32'h0, 1'b0, rd);
    `EBLS_CHK(rd, 32'h0000CAFE)
    $display("half and word test done, big mode %0d", big);
  endtask

  // Strap is flipped after capture, so the final mode checks prove it stayed fixed
  initial begin
    do_reset(1'b0);
    t_bytes(1'b0);
    t_half(1'b0);
    `EBLS_CHK(big_o, 1'b0)
    do_reset(1'b1);
    t_bytes(1'b1);
    t_half(1'b1);
    `EBLS_CHK(big_o, 1'b1)
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    summarize();
  end
endmodule // ebls_top_test
